/* dv/asp_checker_properties.sv */
// Purpose: Port-level properties of the async serial port
// Assumes: Register strobes are single-cycle, never wr and rd together
// Notes:   Flags are seen only through irq_req and control reads
module asp_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Register port
    input asp_pkg::asp_sfr_req_s sfr_req,
    input wire logic [7:0] sfr_rdata,
    // Timer and interrupt
    input wire logic tx_timer_ovf,
    input wire logic irq_enable,
    input wire logic irq_req,
    // Transmit line
    input wire logic serial_tx_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    import asp_pkg::*;

    wire logic ctrl_wr = sfr_req.wr && (sfr_req.addr == ASP_ADDR_CTRL);
    wire logic ctrl_rd = sfr_req.rd && (sfr_req.addr == ASP_ADDR_CTRL);
    wire logic stray_rd = sfr_req.rd && (sfr_req.addr != ASP_ADDR_CTRL)
        && (sfr_req.addr != ASP_ADDR_DATA);
    logic [7:0] ctrl_shadow_r;

    // Bits 7 and 5..3 are owned by software alone, so a shadow suffices
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_shadow_r <= ASP_CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_shadow_r <= sfr_req.wdata;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    AST_IRQ_GATED: assert property (
        irq_req |-> $past(irq_enable)) else $error("irq while disabled");
    AST_CTRL_IRQ: assert property (
        ctrl_rd && irq_enable |=> irq_req == (|sfr_rdata[1:0]))
        else $error("irq disagrees with done flags");
    AST_FLAG_HOLD: assert property (
        irq_req && irq_enable && !$past(ctrl_wr) |=> irq_req)
        else $error("done flag dropped without a write");
    AST_STRAY_RD: assert property (
        stray_rd |=> sfr_rdata == 8'h00) else $error("unmapped read not zero");
    AST_IDLE_RDATA: assert property (
        !sfr_req.rd |=> sfr_rdata == 8'h00) else $error("rdata without read");
    AST_BIT6_ONE: assert property (
        ctrl_rd |=> sfr_rdata[ASP_BIT_UNUSED]) else $error("bit 6 not one");
    AST_CTRL_BACK: assert property (
        ctrl_rd |=> sfr_rdata[7:3] == {ctrl_shadow_r[7], 1'b1,
        ctrl_shadow_r[5:3]}) else $error("control bits not as written");
    AST_TX_ON_TICK: assert property (
        $changed(serial_tx_pin) |-> $past(tx_timer_ovf)
        || $past(tx_timer_ovf, 2)) else $error("tx moved off a bit tick");
    AST_RESET_IDLE: assert property (
        $rose(reset_n) |-> serial_tx_pin && !irq_req)
        else $error("line not idle after reset");
endmodule

bind asp_top asp_checker chk_u (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata),
    .tx_timer_ovf(tx_timer_ovf),
    .irq_enable(irq_enable),
    .irq_req(irq_req),
    .serial_tx_pin(serial_tx_pin)
);

/* dv/asp_peer.sv */
// Purpose: Far-side serial port sending and receiving frames
// Assumes: Bit time is a whole number of core_clk cycles
// Notes:   Frames received are reported by a rolling count
module asp_peer #(
    parameter int BIT_CYCLES = 32
) (
    // Clock
    input wire logic core_clk,
    // Frame format
    input wire logic nine_mode,
    // Lines
    input wire logic serial_tx_pin,
    output logic serial_rx_pin,
    // Received frame
    output logic [7:0] got_data,
    output logic got_ninth,
    output logic got_stop,
    output logic [7:0] got_cnt
);
    timeunit 1ns;
    timeprecision 1ps;

    // Stop is given by the caller so a bad stop can be sent on purpose
    task automatic send_frame(input logic nine, input logic [7:0] d,
        input logic n9, input logic stop);
        logic [10:0] bits;
        bits = {stop, nine ? n9 : stop, d, 1'b0};
        for (int i = 0; i < (nine ? 11 : 10); i++) begin
            serial_rx_pin <= bits[i];
            repeat (BIT_CYCLES) @(posedge core_clk);
        end
        serial_rx_pin <= 1'b1;
        repeat (BIT_CYCLES) @(posedge core_clk);
    endtask

    initial begin
        logic [10:0] bits;
        int n;
        serial_rx_pin = 1'b1;
        got_cnt = 8'h00;
        bits = '1;
        forever begin
            @(negedge serial_tx_pin);
            n = nine_mode ? 10 : 9;
            repeat (BIT_CYCLES / 2) @(posedge core_clk);
            for (int i = 1; i <= n; i++) begin
                repeat (BIT_CYCLES) @(posedge core_clk);
                bits[i] = serial_tx_pin;
            end
            got_data = bits[8:1];
            got_ninth = bits[9];
            got_stop = bits[n];
            got_cnt = got_cnt + 8'h01;
        end
    end
endmodule

/* dv/test_async_serial_port_8_9_bit.sv */
// Purpose: Register-level test of the async serial port
// Assumes: Baud timer ticks every cycle, reload gives 16-cycle overflows
// Notes:   One idle cycle separates register accesses
module test_async_serial_port_8_9_bit;
    timeunit 1ns;
    timeprecision 1ps;
    import asp_pkg::*;

    logic core_clk = 1'b0;
    logic reset_n;
    asp_sfr_req_s req;
    logic [7:0] rdata, got_data, got_cnt;
    logic [3:0] ovf_div = 4'h0;
    logic tx_ovf = 1'b0;
    logic irq_en, irq, rx_pin, tx_pin, nine, got_ninth, got_stop;
    int err_count = 0;
    int total_checks = 0;

    asp_top dut_u (
        .core_clk(core_clk), .reset_n(reset_n),
        .sfr_req(req), .sfr_rdata(rdata),
        .timer_run(1'b1), .timer_tick(1'b1),
        // Overflow every 256 - reload ticks: 16 here, short runs
        .baud_reload_value(8'hf0), .tx_timer_ovf(tx_ovf),
        .irq_enable(irq_en), .irq_req(irq),
        .serial_rx_pin(rx_pin), .serial_tx_pin(tx_pin)
    );

    asp_peer #(.BIT_CYCLES(32)) peer_u (
        .core_clk(core_clk), .nine_mode(nine),
        .serial_tx_pin(tx_pin), .serial_rx_pin(rx_pin),
        .got_data(got_data), .got_ninth(got_ninth),
        .got_stop(got_stop), .got_cnt(got_cnt)
    );

    initial forever #2.5 core_clk = ~core_clk;

    // Transmit timer overflow every 16 cycles, matching the receive copy
    always @(posedge core_clk) begin
        ovf_div <= ovf_div + 4'h1;
        tx_ovf <= (ovf_div == 4'hf);
    end

    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
        input string what);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got,
                exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge core_clk);
        req <= '0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp,
        input string what);
        req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge core_clk);
        req <= '0;
        #1 chk(rdata, exp, what);
        @(posedge core_clk);
    endtask

    task automatic tx_case(input logic [7:0] c, input logic [7:0] d,
        input logic n9);
        logic [7:0] n0;
        wr(ASP_ADDR_CTRL, c);
        nine <= c[7];
        n0 = got_cnt;
        wr(ASP_ADDR_DATA, d);
        for (int i = 0; i < 1000 && got_cnt == n0; i++) @(posedge core_clk);
        chk(got_cnt, n0 + 8'h01, "tx frame seen");
        chk(got_data, d, "tx data");
        chk({7'h00, got_ninth}, {7'h00, n9}, "tx ninth");
        chk({7'h00, got_stop}, 8'h01, "tx stop");
        rd(ASP_ADDR_CTRL, c | 8'h42, "tx done flag");
        chk({7'h00, irq}, 8'h01, "irq on tx done");
    endtask

    task automatic rx_case(input logic [7:0] c, input logic [7:0] d,
        input logic n9, input logic stop, input logic [7:0] ed,
        input logic [7:0] ec);
        wr(ASP_ADDR_CTRL, c);
        peer_u.send_frame(c[7], d, n9, stop);
        rd(ASP_ADDR_DATA, ed, "rx latch");
        rd(ASP_ADDR_CTRL, ec, "rx control");
    endtask

    initial begin
        #100000;
        err_count++;
        $display("mismatch at %0t: run did not finish", $time);
        report_and_stop();
    end

    initial begin
        req = '0;
        reset_n = 1'b0;
        irq_en = 1'b1;
        nine = 1'b0;
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        rd(ASP_ADDR_CTRL, 8'h40, "ctrl reset");
        rd(ASP_ADDR_DATA, 8'h00, "data reset");
        wr(ASP_ADDR_CTRL, 8'hbc);
        wr(8'h9a, 8'hff);
        rd(ASP_ADDR_CTRL, 8'hfc, "bit 6 and mode");
        rd(8'h9a, 8'h00, "unmapped");
        // Ninth transmit bit cleared in 8-bit mode: stop must still be 1
        tx_case(8'h00, 8'ha5, 1'b1);
        tx_case(8'h80, 8'h3c, 1'b0);
        tx_case(8'h88, 8'hc3, 1'b1);
        irq_en <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1 chk({7'h00, irq}, 8'h00, "irq masked");
        @(posedge core_clk);
        irq_en <= 1'b1;
        rx_case(8'h10, 8'h5a, 1'b0, 1'b1, 8'h5a, 8'h55);
        rx_case(8'h15, 8'hc3, 1'b0, 1'b1, 8'h5a, 8'h55);
        rx_case(8'h00, 8'h11, 1'b0, 1'b1, 8'h5a, 8'h40);
        rx_case(8'h30, 8'h66, 1'b0, 1'b0, 8'h5a, 8'h70);
        rx_case(8'h90, 8'h44, 1'b0, 1'b0, 8'h44, 8'hd1);
        rx_case(8'hb0, 8'h22, 1'b0, 1'b1, 8'h44, 8'hf0);
        rx_case(8'hb0, 8'h33, 1'b1, 1'b1, 8'h33, 8'hf5);
        // Address matched: slave drops its filter, data byte gets in
        rx_case(8'h90, 8'h77, 1'b0, 1'b1, 8'h77, 8'hd1);
        report_and_stop();
    end
endmodule

/* logic/asp_baud_gen.sv */
// Purpose: Receive copy of the 8-bit auto-reload baud timer
// Assumes: timer_tick is the one-cycle timer clock enable
// Notes:   Overflow runs at twice the bit rate; half_tick marks them
module asp_baud_gen #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Timer control
    input wire logic timer_run,
    input wire logic timer_tick,
    input wire logic [WIDTH-1:0] reload,
    input wire logic force_reload,
    // Overflow pulse
    output logic half_tick
);
    import asp_pkg::*;

    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;
    logic top;

    assign top = count_r == {WIDTH{1'b1}};
    assign half_tick = timer_run && timer_tick && top && !force_reload;
    assign count_nxt = (force_reload || half_tick) ? reload :
        (timer_run && timer_tick) ? count_r + 1'b1 : count_r;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end
endmodule

/* logic/asp_edge_det.sv */
// Purpose: Falling edge detector for the receive line
// Assumes: Line input synchronous to core_clk
// Notes:   Previous level resets to idle so reset never fakes a start
module asp_edge_det (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Line
    input wire logic line_in,
    output logic fall
);
    import asp_pkg::*;

    logic prev_r;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            prev_r <= ASP_LINE_IDLE;
        end else begin
            prev_r <= line_in;
        end
    end

    assign fall = prev_r && !line_in;
endmodule

/* logic/asp_pkg.sv */
// Purpose: Shared constants and types for the async serial port
// Assumes: Register port addresses are the 8-bit special register space
// Notes:   Control register bit 6 is hard-wired high
//
// Summary of operation
// - 8-bit frame: start, 8 data LSB first, stop
// - 8-bit receive: data to latch, stop to ninth
// - Data buffer write starts transmission
// - Transmit-done set at stop bit start
// - Receive only while receive enable is one
// - 8-bit load needs rx-done clear, optional stop check
// - Overrun keeps first byte, drops later character
// - Load writes latch, ninth bit, rx-done together
// - Interrupt request when either done flag set
// - 9-bit frame: start, 8 data, ninth, stop
// - Transmitted ninth bit from ninth_tx_bit register
// - 9-bit receive: ninth bit stored, stop ignored
// - Multiprocessor filter loads only ninth bit one
// - Control bit 7 selects 8 or 9 bit
// - Control bit 6 reads one, ignores writes
// - Done flags cleared only by software write
// - Rx-done set when stop bit sampled
// - Data buffer read returns receive latch
// - Bit clocks are timer overflow divided two
// - Receive timer reloaded on start detection
package asp_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ASP_ADDR_CTRL = 8'h98;
    localparam logic [7:0] ASP_ADDR_DATA = 8'h99;
    localparam logic [7:0] ASP_CTRL_RESET = 8'h40;
    localparam logic [7:0] ASP_DATA_RESET = 8'h00;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int ASP_BIT_MODE = 7;
    localparam int ASP_BIT_UNUSED = 6;
    localparam int ASP_BIT_MCE = 5;
    localparam int ASP_BIT_REN = 4;
    localparam int ASP_BIT_TB8 = 3;
    localparam int ASP_BIT_RB8 = 2;
    localparam int ASP_BIT_TI = 1;
    localparam int ASP_BIT_RI = 0;

    // ------------------------------------------------------------
    // Frame and timing
    // ------------------------------------------------------------
    localparam int ASP_DATA_BITS = 8;
    localparam logic [2:0] ASP_LAST_DATA = 3'h7;
    localparam logic [7:0] ASP_TIMER_TOP = 8'hff;
    localparam logic ASP_LINE_IDLE = 1'b1;
    localparam logic ASP_LINE_START = 1'b0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } asp_sfr_req_s;

    typedef enum logic [1:0] {
        ASP_TX_IDLE, ASP_TX_DATA, ASP_TX_NINTH, ASP_TX_STOP
    } asp_tx_state_e;

    typedef enum logic [2:0] {
        ASP_RX_IDLE, ASP_RX_START, ASP_RX_DATA, ASP_RX_NINTH, ASP_RX_STOP
    } asp_rx_state_e;

endpackage

/* logic/asp_top.sv */
// Purpose: Full-duplex async serial port, 8-bit and 9-bit frames
// Assumes: Register port strobes are single-cycle and synchronous
// Notes:   Read data appears one cycle after the read strobe
module asp_top (
    // Clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // Register port
    input asp_pkg::asp_sfr_req_s sfr_req,
    output logic [7:0] sfr_rdata,
    // Baud timer
    input wire logic timer_run,
    input wire logic timer_tick,
    input wire logic [7:0] baud_reload_value,
    input wire logic tx_timer_ovf,
    // Interrupt
    input wire logic irq_enable,
    output logic irq_req,
    // Serial lines
    input wire logic serial_rx_pin,
    output logic serial_tx_pin
);
    import asp_pkg::*;

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    logic frame_mode_select_r;
    logic multiproc_filter_enable_r;
    logic receive_enable_bit_r;
    logic ninth_tx_bit_r;
    logic ninth_rx_bit_r;
    logic tx_done_flag_r;
    logic rx_done_flag_r;
    logic [7:0] rx_latch_r;
    logic [7:0] ctrl_view;

    logic wr_ctrl;
    logic wr_data;
    logic rd_ctrl;
    logic rd_data;

    assign wr_ctrl = sfr_req.wr && sfr_req.addr == ASP_ADDR_CTRL;
    assign wr_data = sfr_req.wr && sfr_req.addr == ASP_ADDR_DATA;
    assign rd_ctrl = sfr_req.rd && sfr_req.addr == ASP_ADDR_CTRL;
    assign rd_data = sfr_req.rd && sfr_req.addr == ASP_ADDR_DATA;

    // Bit 6 is constant one; writes to it land nowhere
    assign ctrl_view = {frame_mode_select_r, 1'b1,
        multiproc_filter_enable_r, receive_enable_bit_r,
        ninth_tx_bit_r, ninth_rx_bit_r, tx_done_flag_r,
        rx_done_flag_r};

    // ------------------------------------------------------------
    // Transmit bit clock
    // ------------------------------------------------------------
    logic tx_phase_r;
    logic tx_bit_tick;

    // Every second overflow of the shared timer is one bit time
    assign tx_bit_tick = tx_timer_ovf && tx_phase_r;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_phase_r <= 1'b0;
        end else if (tx_timer_ovf) begin
            tx_phase_r <= !tx_phase_r;
        end
    end

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    asp_tx_state_e tx_state_r;
    asp_tx_state_e tx_state_nxt;
    logic [7:0] tx_shift_r;
    logic [7:0] tx_shift_nxt;
    logic [2:0] tx_cnt_r;
    logic [2:0] tx_cnt_nxt;
    logic tx_pend_r;
    logic tx_pin_nxt;
    logic tx_start;
    logic tx_set_done;

    assign tx_start = tx_bit_tick && tx_pend_r &&
        tx_state_r == ASP_TX_IDLE;

    always_comb begin
        tx_state_nxt = tx_state_r;
        tx_shift_nxt = tx_shift_r;
        tx_cnt_nxt = tx_cnt_r;
        tx_pin_nxt = serial_tx_pin;
        tx_set_done = 1'b0;
        if (tx_bit_tick) begin
            unique case (tx_state_r)
                ASP_TX_IDLE: begin
                    tx_pin_nxt = ASP_LINE_IDLE;
                    if (tx_pend_r) begin
                        tx_pin_nxt = ASP_LINE_START;
                        tx_cnt_nxt = '0;
                        tx_state_nxt = ASP_TX_DATA;
                    end
                end
                ASP_TX_DATA: begin
                    tx_pin_nxt = tx_shift_r[0];
                    tx_shift_nxt = {1'b0, tx_shift_r[7:1]};
                    tx_cnt_nxt = tx_cnt_r + 3'h1;
                    if (tx_cnt_r == ASP_LAST_DATA) begin
                        tx_state_nxt = frame_mode_select_r ?
                            ASP_TX_NINTH : ASP_TX_STOP;
                    end
                end
                ASP_TX_NINTH: begin
                    tx_pin_nxt = ninth_tx_bit_r;
                    tx_state_nxt = ASP_TX_STOP;
                end
                ASP_TX_STOP: begin
                    tx_pin_nxt = ASP_LINE_IDLE;
                    tx_set_done = 1'b1;
                    tx_state_nxt = ASP_TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_state_r <= ASP_TX_IDLE;
            tx_cnt_r <= '0;
            serial_tx_pin <= ASP_LINE_IDLE;
        end else begin
            tx_state_r <= tx_state_nxt;
            tx_cnt_r <= tx_cnt_nxt;
            serial_tx_pin <= tx_pin_nxt;
        end
    end

    // A write waits for the next bit tick to start, so the start bit
    // is always a full bit wide; a later write replaces the byte.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_shift_r <= ASP_DATA_RESET;
            tx_pend_r <= 1'b0;
        end else if (wr_data) begin
            tx_shift_r <= sfr_req.wdata;
            tx_pend_r <= 1'b1;
        end else begin
            tx_shift_r <= tx_shift_nxt;
            if (tx_start) begin
                tx_pend_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Receive timing
    // ------------------------------------------------------------
    logic rx_fall;
    logic rx_half_tick;
    logic rx_phase_r;
    logic rx_sample;
    logic rx_start_det;
    asp_rx_state_e rx_state_r;
    asp_rx_state_e rx_state_nxt;

    asp_edge_det u_edge (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .line_in(serial_rx_pin),
        .fall(rx_fall)
    );

    assign rx_start_det = rx_fall && receive_enable_bit_r &&
        rx_state_r == ASP_RX_IDLE;

    asp_baud_gen #(.WIDTH(8)) u_rx_baud (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .timer_run(timer_run),
        .timer_tick(timer_tick),
        .reload(baud_reload_value),
        .force_reload(rx_start_det),
        .half_tick(rx_half_tick)
    );

    // First overflow after the edge is half a bit in: mid start bit
    assign rx_sample = rx_half_tick && !rx_phase_r;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_phase_r <= 1'b0;
        end else if (rx_start_det) begin
            rx_phase_r <= 1'b0;
        end else if (rx_half_tick) begin
            rx_phase_r <= !rx_phase_r;
        end
    end

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    logic [7:0] rx_shift_r;
    logic [7:0] rx_shift_nxt;
    logic [2:0] rx_cnt_r;
    logic [2:0] rx_cnt_nxt;
    logic rx_ninth_r;
    logic rx_ninth_nxt;
    logic rx_at_stop;
    logic rx_bit9;
    logic rx_ok;
    logic rx_load;

    assign rx_at_stop = rx_sample && rx_state_r == ASP_RX_STOP;
    // Ninth bit is the stop level in 8-bit mode, the data bit in 9-bit
    assign rx_bit9 = frame_mode_select_r ? rx_ninth_r :
        serial_rx_pin;
    // Same enable bit checks stop level or filters addresses
    assign rx_ok = !rx_done_flag_r &&
        (!multiproc_filter_enable_r || rx_bit9);
    assign rx_load = rx_at_stop && rx_ok;

    always_comb begin
        rx_state_nxt = rx_state_r;
        rx_shift_nxt = rx_shift_r;
        rx_cnt_nxt = rx_cnt_r;
        rx_ninth_nxt = rx_ninth_r;
        if (!receive_enable_bit_r) begin
            rx_state_nxt = ASP_RX_IDLE;
        end else if (rx_start_det) begin
            rx_state_nxt = ASP_RX_START;
        end else if (rx_sample) begin
            unique case (rx_state_r)
                ASP_RX_IDLE: begin
                    rx_state_nxt = ASP_RX_IDLE;
                end
                ASP_RX_START: begin
                    // Glitch shorter than half a bit is not a start
                    rx_cnt_nxt = '0;
                    rx_state_nxt = (serial_rx_pin == ASP_LINE_START) ?
                        ASP_RX_DATA : ASP_RX_IDLE;
                end
                ASP_RX_DATA: begin
                    rx_shift_nxt = {serial_rx_pin, rx_shift_r[7:1]};
                    rx_cnt_nxt = rx_cnt_r + 3'h1;
                    if (rx_cnt_r == ASP_LAST_DATA) begin
                        rx_state_nxt = frame_mode_select_r ?
                            ASP_RX_NINTH : ASP_RX_STOP;
                    end
                end
                ASP_RX_NINTH: begin
                    rx_ninth_nxt = serial_rx_pin;
                    rx_state_nxt = ASP_RX_STOP;
                end
                ASP_RX_STOP: begin
                    rx_state_nxt = ASP_RX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_state_r <= ASP_RX_IDLE;
            rx_shift_r <= '0;
            rx_cnt_r <= '0;
            rx_ninth_r <= 1'b0;
        end else begin
            rx_state_r <= rx_state_nxt;
            rx_shift_r <= rx_shift_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            rx_ninth_r <= rx_ninth_nxt;
        end
    end

    // Latch changes only on an accepted character, the ninth bit also on a control write, so
    // an overrun leaves the first byte intact for software.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_latch_r <= ASP_DATA_RESET;
            ninth_rx_bit_r <= ASP_CTRL_RESET[ASP_BIT_RB8];
        end else if (rx_load) begin
            rx_latch_r <= rx_shift_r;
            ninth_rx_bit_r <= rx_bit9;
        end else if (wr_ctrl) begin
            ninth_rx_bit_r <= sfr_req.wdata[ASP_BIT_RB8];
        end
    end

    // ------------------------------------------------------------
    // Control register writes and done flags
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            frame_mode_select_r <= ASP_CTRL_RESET[ASP_BIT_MODE];
            multiproc_filter_enable_r <= ASP_CTRL_RESET[ASP_BIT_MCE];
            receive_enable_bit_r <= ASP_CTRL_RESET[ASP_BIT_REN];
            ninth_tx_bit_r <= ASP_CTRL_RESET[ASP_BIT_TB8];
        end else if (wr_ctrl) begin
            frame_mode_select_r <= sfr_req.wdata[ASP_BIT_MODE];
            multiproc_filter_enable_r <= sfr_req.wdata[ASP_BIT_MCE];
            receive_enable_bit_r <= sfr_req.wdata[ASP_BIT_REN];
            ninth_tx_bit_r <= sfr_req.wdata[ASP_BIT_TB8];
        end
    end

    // Hardware only ever sets; a set in the clearing cycle wins
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tx_done_flag_r <= ASP_CTRL_RESET[ASP_BIT_TI];
            rx_done_flag_r <= ASP_CTRL_RESET[ASP_BIT_RI];
        end else begin
            if (tx_set_done) begin
                tx_done_flag_r <= 1'b1;
            end else if (wr_ctrl) begin
                tx_done_flag_r <= sfr_req.wdata[ASP_BIT_TI];
            end
            if (rx_load) begin
                rx_done_flag_r <= 1'b1;
            end else if (wr_ctrl) begin
                rx_done_flag_r <= sfr_req.wdata[ASP_BIT_RI];
            end
        end
    end

    // ------------------------------------------------------------
    // Read data and interrupt request
    // ------------------------------------------------------------
    logic [7:0] rdata_nxt;
    logic irq_nxt;

    assign rdata_nxt = rd_ctrl ? ctrl_view :
        rd_data ? rx_latch_r : 8'h00;
    assign irq_nxt = irq_enable &&
        (tx_done_flag_r || rx_done_flag_r);

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sfr_rdata <= 8'h00;
            irq_req <= 1'b0;
        end else begin
            sfr_rdata <= rdata_nxt;
            irq_req <= irq_nxt;
        end
    end
endmodule
